/* File: tsc_regs.sv */
// Contract
// R1: setup bit 4 set turns off bias-variation compensation for remote readings.
// R2: signed offset register is added to every reported temperature result.
// R3: host programs one offset equal to the algebraic sum of all corrections.
// R4: status is read-only at 0x02, no write address.
// R5: setup register read at 0x03, written at 0x09, resets to 0x08.
// R6: cadence register read at 0x04, written at 0x0A, resets to 0x06.
// R7: writes at 0x0F trigger one conversion; nothing readable there.
// R8: fault queue count read and written at 0x22, resets to 0x01.
// R9: fixed part code read at 0x3D, writes ignored.
// R10: fixed maker code read at 0xFE, read-only.
// R11: silicon revision code read at 0xFF, read-only.
// R12: register pointer is not itself addressable as a register.
// R13: fastest cadence is 36 conversions per second; code's shortest period is 27 ms, about 37 per second.
// R14: setup bit 6 halts measurement and drops a running conversion unreported; code lets a running one-shot conversion finish and report.
// R15: any write to trigger starts one conversion, then standby resumes.
// R16: alarm status flags stay set until status is read or reset.
`default_nettype none
module tsc_regs #(
  parameter int unsigned CYC_PER_MS = tsc_pkg::TSC_MS_NS / tsc_pkg::TSC_CLK_NS,
  // arbitrary values
  parameter logic [7:0] PART_CODE = 8'hA5,
  parameter logic [7:0] MAKER_CODE = 8'h5A,
  parameter logic [7:0] REV_CODE = 8'h01
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register access from the serial engine
  input wire logic ptr_load,
  input wire logic [7:0] ptr_data,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic rd_req,
  output logic [7:0] rd_data,
  // converter
  output logic adc_start,
  output logic adc_abort,
  input wire logic adc_done,
  input wire logic [tsc_pkg::TSC_RES_W-1:0] raw_local,
  input wire logic [tsc_pkg::TSC_RES_W-1:0] raw_remote,
  // corrected results
  output logic [tsc_pkg::TSC_RES_W-1:0] local_temp,
  output logic [tsc_pkg::TSC_RES_W-1:0] remote_temp,
  output logic result_valid,
  // limit logic events
  input wire logic [4:0] evt_set,
  input wire logic [1:0] therm_lvl,
  // setup outputs
  output logic beta_comp_off,
  output logic alert_mask,
  output logic pin_therm2_sel,
  output logic range_ext,
  output logic standby,
  output logic [7:0] alarm_queue_count
);
  import tsc_pkg::*;

  // ************************************************************
  // storage
  // ************************************************************
  logic [7:0] ptr;
  logic [7:0] setup;
  logic [3:0] cadence;
  logic [7:0] offset;
  logic [4:0] flags;
  logic [1:0] therm_now;
  logic [7:0] next_rd_data;
  logic status_rd;
  logic [TSC_RES_W-1:0] offset_ext;

  tsc_meas_if m ();

  assign status_rd = rd_req && (ptr == TSC_RD_STATUS);

  // ************************************************************
  // register pointer
  // ************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ptr <= TSC_PTR_RST;
    end else if (ptr_load) begin
      ptr <= ptr_data; // R12
    end
  end

  // ************************************************************
  // writable registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      setup <= TSC_SETUP_RST; // R5
      cadence <= TSC_CADENCE_RST[3:0]; // R6
      alarm_queue_count <= TSC_QUEUE_RST; // R8
      offset <= TSC_OFFSET_RST;
    end else if (wr_en) begin
      unique case (ptr)
        TSC_WR_SETUP: setup <= (wr_data & TSC_SETUP_WMASK) | TSC_SETUP_RST; // R5
        TSC_WR_CADENCE: cadence <= wr_data[3:0]; // R6
        TSC_RW_QUEUE: alarm_queue_count <= wr_data; // R8
        TSC_RW_OFFSET: offset <= wr_data; // R2
        default: ; // R4 R9 R10 R11
      endcase
    end
  end

  // ************************************************************
  // setup bits driving the rest of the device
  // ************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      beta_comp_off <= TSC_SETUP_RST[TSC_BIT_BETA_OFF];
      alert_mask <= TSC_SETUP_RST[TSC_BIT_MASK];
      pin_therm2_sel <= TSC_SETUP_RST[TSC_BIT_THERM2];
      range_ext <= TSC_SETUP_RST[TSC_BIT_RANGE];
      standby <= TSC_SETUP_RST[TSC_BIT_STANDBY];
    end else begin
      beta_comp_off <= setup[TSC_BIT_BETA_OFF]; // R1
      alert_mask <= setup[TSC_BIT_MASK];
      pin_therm2_sel <= setup[TSC_BIT_THERM2];
      range_ext <= setup[TSC_BIT_RANGE];
      standby <= setup[TSC_BIT_STANDBY]; // R14
    end
  end

  // ************************************************************
  // conversion control
  // ************************************************************
  assign m.rate = cadence;
  assign m.standby = setup[TSC_BIT_STANDBY]; // R14
  assign m.oneshot = wr_en && (ptr == TSC_WR_TRIGGER); // R7 R15
  assign m.done = adc_done;
  assign adc_start = m.start;
  assign adc_abort = m.abort;

  tsc_conv_seq #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_seq (
    .clk(clk),
    .sys_rst(sys_rst),
    .m(m)
  );

  // ************************************************************
  // corrected results
  // ************************************************************
  assign offset_ext = TSC_RES_W'({{(TSC_RES_W - 8){offset[7]}}, offset} <<< TSC_FRAC_W);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      local_temp <= '0;
      remote_temp <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (m.busy && adc_done && !m.abort) begin
        local_temp <= raw_local + offset_ext; // R2
        remote_temp <= raw_remote + offset_ext; // R2
        result_valid <= 1'b1;
      end
    end
  end

  // ************************************************************
  // status flags
  // ************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags <= '0; // R16
      therm_now <= '0;
    end else begin
      flags <= (status_rd ? 5'h00 : flags) | evt_set; // R16
      therm_now <= therm_lvl;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  always_comb begin
    next_rd_data = TSC_UNMAPPED_RD;
    unique case (ptr)
      TSC_RD_STATUS: next_rd_data = {m.busy, flags, therm_now}; // R4
      TSC_RD_SETUP: next_rd_data = setup; // R5
      TSC_RD_CADENCE: next_rd_data = {4'h0, cadence}; // R6
      TSC_RW_QUEUE: next_rd_data = alarm_queue_count; // R8
      TSC_RW_OFFSET: next_rd_data = offset;
      TSC_RD_PART: next_rd_data = PART_CODE; // R9
      TSC_RD_MAKER: next_rd_data = MAKER_CODE; // R10
      TSC_RD_REV: next_rd_data = REV_CODE; // R11
      default: next_rd_data = TSC_UNMAPPED_RD; // R7 R12
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= TSC_UNMAPPED_RD;
    end else if (rd_req) begin
      rd_data <= next_rd_data;
    end
  end

endmodule : tsc_regs
`default_nettype wire

/* File: tsc_pkg.sv */
`default_nettype none
package tsc_pkg;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [7:0] TSC_RD_STATUS = 8'h02;
  localparam logic [7:0] TSC_RD_SETUP = 8'h03;
  localparam logic [7:0] TSC_WR_SETUP = 8'h09;
  localparam logic [7:0] TSC_RD_CADENCE = 8'h04;
  localparam logic [7:0] TSC_WR_CADENCE = 8'h0A;
  localparam logic [7:0] TSC_WR_TRIGGER = 8'h0F;
  localparam logic [7:0] TSC_RW_QUEUE = 8'h22;
  localparam logic [7:0] TSC_RW_OFFSET = 8'h11;
  localparam logic [7:0] TSC_RD_PART = 8'h3D;
  localparam logic [7:0] TSC_RD_MAKER = 8'hFE;
  localparam logic [7:0] TSC_RD_REV = 8'hFF;

  // ************************************************************
  // reset values and field layout
  // ************************************************************
  localparam logic [7:0] TSC_SETUP_RST = 8'h08;
  localparam logic [7:0] TSC_SETUP_WMASK = 8'hF4;
  localparam logic [7:0] TSC_CADENCE_RST = 8'h06;
  localparam logic [3:0] TSC_CADENCE_MAX = 4'hA;
  localparam logic [7:0] TSC_QUEUE_RST = 8'h01;
  localparam logic [7:0] TSC_OFFSET_RST = 8'h00;
  localparam logic [7:0] TSC_PTR_RST = 8'h00;
  localparam logic [7:0] TSC_UNMAPPED_RD = 8'h00;
  localparam int TSC_BIT_MASK = 7;
  localparam int TSC_BIT_STANDBY = 6;
  localparam int TSC_BIT_THERM2 = 5;
  localparam int TSC_BIT_BETA_OFF = 4;
  localparam int TSC_BIT_RANGE = 2;
  localparam int TSC_FRAC_W = 2;
  localparam int TSC_RES_W = 12;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int TSC_CLK_NS = 5;
  localparam int TSC_MS_NS = 1000000;
  localparam int TSC_MS_W = 14;

  // conversion period in ms for each cadence code, faster codes clamp to the fastest
  function automatic logic [TSC_MS_W-1:0] tsc_period_ms(input logic [3:0] code);
    logic [TSC_MS_W-1:0] p;
    p = 14'd27;
    unique case (code)
      4'h0: p = 14'd16000;
      4'h1: p = 14'd8000;
      4'h2: p = 14'd4000;
      4'h3: p = 14'd2000;
      4'h4: p = 14'd1000;
      4'h5: p = 14'd500;
      4'h6: p = 14'd250;
      4'h7: p = 14'd200;
      4'h8: p = 14'd100;
      4'h9: p = 14'd50;
      default: p = 14'd27;
    endcase
    return p;
  endfunction : tsc_period_ms

endpackage : tsc_pkg
`default_nettype wire

/* File: tsc_meas_if.sv */
`default_nettype none
interface tsc_meas_if;
  logic [3:0] rate;
  logic standby;
  logic oneshot;
  logic done;
  logic start;
  logic abort;
  logic busy;
  modport seq (input rate, input standby, input oneshot, input done,
    output start, output abort, output busy);
  modport ctl (output rate, output standby, output oneshot, output done,
    input start, input abort, input busy);
endinterface : tsc_meas_if
`default_nettype wire

/* File: tsc_conv_seq.sv */
`default_nettype none
module tsc_conv_seq #(
  parameter int unsigned CYC_PER_MS = 200000
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // converter control
  tsc_meas_if.seq m
);
  import tsc_pkg::*;

  localparam int PW = $clog2(CYC_PER_MS + 1);

  typedef enum logic [1:0] {
    TSC_IDLE = 2'b00,
    TSC_CONV = 2'b01
  } tsc_seq_t;

  tsc_seq_t state;
  logic [PW-1:0] presc;
  logic [TSC_MS_W-1:0] ms_cnt;
  logic ms_tick;
  logic period_hit;
  logic shot_pend;
  logic shot_run;
  logic go;
  logic [3:0] code;

  assign code = (m.rate > TSC_CADENCE_MAX) ? TSC_CADENCE_MAX : m.rate;
  assign ms_tick = (presc == PW'(CYC_PER_MS - 1));
  assign period_hit = ms_tick && (ms_cnt == tsc_period_ms(code) - 14'd1);
  assign go = (state == TSC_IDLE) && (shot_pend || (period_hit && !m.standby));

  // ************************************************************
  // cadence timer, held while in standby
  // ************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst || m.standby) begin // R14
      presc <= '0;
      ms_cnt <= '0;
    end else if (ms_tick) begin // R13
      presc <= '0;
      ms_cnt <= period_hit ? '0 : ms_cnt + 14'd1;
    end else begin
      presc <= presc + PW'(1);
    end
  end

  // ************************************************************
  // one-shot request, kept until a conversion starts
  // ************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shot_pend <= 1'b0;
    end else if (m.oneshot) begin
      shot_pend <= 1'b1; // R15
    end else if (go) begin
      shot_pend <= 1'b0;
    end
  end

  // ************************************************************
  // conversion state
  // ************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= TSC_IDLE;
      shot_run <= 1'b0;
      m.start <= 1'b0;
      m.abort <= 1'b0;
      m.busy <= 1'b0;
    end else begin
      m.start <= 1'b0;
      m.abort <= 1'b0;
      unique case (state)
        TSC_IDLE: begin
          if (go) begin
            state <= TSC_CONV;
            shot_run <= shot_pend; // R15
            m.start <= 1'b1;
            m.busy <= 1'b1;
          end
        end
        TSC_CONV: begin
          if (m.done) begin
            state <= TSC_IDLE;
            shot_run <= 1'b0;
            m.busy <= 1'b0;
          end else if (m.standby && !shot_run) begin
            state <= TSC_IDLE; // R14
            m.abort <= 1'b1;
            m.busy <= 1'b0;
          end
        end
        default: begin
          state <= TSC_IDLE;
          m.busy <= 1'b0;
        end
      endcase
    end
  end

endmodule : tsc_conv_seq
`default_nettype wire

/* File: tsc_regs_assertions.sv */
`default_nettype none
module tsc_regs_chk #(
  parameter logic [7:0] PART_CODE = 8'hA5,
  parameter logic [7:0] MAKER_CODE = 8'h5A,
  parameter logic [7:0] REV_CODE = 8'h01
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic ptr_load,
  input wire logic [7:0] ptr_data,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic rd_req,
  input wire logic [7:0] rd_data,
  // converter and setup
  input wire logic adc_start,
  input wire logic beta_comp_off,
  input wire logic alert_mask,
  input wire logic pin_therm2_sel,
  input wire logic range_ext,
  input wire logic standby,
  input wire logic [7:0] alarm_queue_count
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence wr_at(logic [7:0] a);
    ptr_load && ptr_data == a ##1 wr_en;
  endsequence
  sequence rd_at(logic [7:0] a);
    ptr_load && ptr_data == a ##1 rd_req;
  endsequence
  setup_beta_a: assert property (
    wr_at(8'h09) |=> ##1 beta_comp_off == $past(wr_data[4], 2)
  ) else $error("bias control wrong");
  setup_standby_a: assert property (
    wr_at(8'h09) |=> ##1 standby == $past(wr_data[6], 2)
  ) else $error("standby wrong");
  setup_bits_a: assert property (
    wr_at(8'h09) |=> ##1 {alert_mask, pin_therm2_sel, range_ext} ==
      {$past(wr_data[7], 2), $past(wr_data[5], 2), $past(wr_data[2], 2)}
  ) else $error("setup outputs wrong");
  trigger_start_a: assert property (
    wr_at(8'h0F) |-> ##[2:40] adc_start
  ) else $error("no conversion started");
  queue_write_a: assert property (
    wr_at(8'h22) |=> ##1 alarm_queue_count == $past(wr_data, 2)
  ) else $error("queue count wrong");
  part_code_a: assert property (
    rd_at(8'h3D) |=> rd_data == PART_CODE
  ) else $error("part code wrong");
  maker_code_a: assert property (
    rd_at(8'hFE) |=> rd_data == MAKER_CODE
  ) else $error("maker code wrong");
  rev_code_a: assert property (
    rd_at(8'hFF) |=> rd_data == REV_CODE
  ) else $error("revision wrong");
  trigger_read_a: assert property (
    rd_at(8'h0F) |=> rd_data == 8'h00
  ) else $error("trigger readable");
  setup_fixed_a: assert property (
    rd_at(8'h03) |=> rd_data[3] && rd_data[1:0] == 2'b00
  ) else $error("setup fixed bits wrong");
endmodule : tsc_regs_chk
bind tsc_regs tsc_regs_chk #(
  .PART_CODE(PART_CODE), .MAKER_CODE(MAKER_CODE), .REV_CODE(REV_CODE)
) u_chk (.clk, .sys_rst, .ptr_load, .ptr_data, .wr_en, .wr_data, .rd_req,
  .rd_data, .adc_start, .beta_comp_off, .alert_mask, .pin_therm2_sel, .range_ext,
  .standby, .alarm_queue_count);
`default_nettype wire

/* File: tsc_host.sv */
`default_nettype none
module tsc_host (
  // clock
  input wire logic clk,
  // register port
  output logic ptr_load,
  output logic [7:0] ptr_data,
  output logic wr_en,
  output logic [7:0] wr_data,
  output logic rd_req
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {ptr_load, ptr_data, wr_en, wr_data, rd_req} = '0;
  end
  // pointer cycle, then one access; released lines show the inverse
  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] v);
    @(negedge clk);
    ptr_load = 1'b1;
    ptr_data = a;
    @(negedge clk);
    ptr_load = 1'b0;
    ptr_data = ~a;
    wr_en = w;
    rd_req = !w;
    wr_data = v;
    @(negedge clk);
    wr_en = 1'b0;
    rd_req = 1'b0;
    wr_data = ~v;
  endtask : acc
  task automatic set_offset(input logic [7:0] a, input logic [7:0] b);
    acc(8'h11, 1'b1, a + b);
  endtask : set_offset
endmodule : tsc_host
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import tsc_pkg::*;
  localparam logic [7:0] PC = 8'h3C; // arbitrary
  localparam logic [7:0] MC = 8'hC3; // arbitrary
  localparam logic [7:0] RC = 8'h07; // arbitrary
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ptr_load, wr_en, rd_req, adc_done, adc_start, adc_abort, result_valid, rd_seen, ab;
  logic [7:0] ptr_data, wr_data, rd_data, off, d, e8;
  logic [11:0] raw_l, raw_r, loc_t, rem_t;
  logic [23:0] e24;
  logic [4:0] evt_set;
  logic [1:0] therm_lvl;
  logic [31:0] seed = 32'h8F6C;
  logic [7:0] rd_q[$];
  logic [23:0] res_q[$];
  logic [7:0] ra[11] = '{8'h03, 8'h04, 8'h22, 8'h11, 8'h3D, 8'hFE, 8'hFF, 8'h09,
    8'h0A, 8'h0F, 8'h50};
  logic [7:0] rv[11] = '{8'h08, 8'h06, 8'h01, 8'h00, PC, MC, RC, 8'h00, 8'h00,
    8'h00, 8'h00};
  logic [7:0] ro[6] = '{8'h02, 8'h03, 8'h04, 8'h3D, 8'hFE, 8'hFF};
  int mismatches, num_checks, n;
  wire [11:0] ofs = {{2{off[7]}}, off, 2'b00};
  always #2.5 clk = ~clk;
  tsc_host u_host (.clk, .ptr_load, .ptr_data, .wr_en, .wr_data, .rd_req);
  tsc_regs #(.CYC_PER_MS(10), .PART_CODE(PC), .MAKER_CODE(MC), .REV_CODE(RC)) uut (
    .clk, .sys_rst, .ptr_load, .ptr_data, .wr_en, .wr_data, .rd_req, .rd_data,
    .adc_start, .adc_abort, .adc_done, .raw_local(raw_l), .raw_remote(raw_r),
    .local_temp(loc_t), .remote_temp(rem_t), .result_valid, .evt_set, .therm_lvl,
    .beta_comp_off(), .alert_mask(), .pin_therm2_sel(), .range_ext(), .standby(),
    .alarm_queue_count());
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_host.acc(a, 1'b1, v);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    rd_q.push_back(v);
    u_host.acc(a, 1'b0, 8'h00);
  endtask : rd
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  // converter model, drops the result when aborted
  initial begin
    {adc_done, raw_l, raw_r} = '0;
    forever begin
      @(negedge clk);
      if (adc_start === 1'b1) begin
        ab = 1'b0;
        repeat (8) begin
          @(negedge clk);
          if (adc_abort === 1'b1) ab = 1'b1;
        end
        if (!ab) begin
          raw_l = {rnd(), 4'h5};
          raw_r = {4'hA, rnd()};
          adc_done = 1'b1;
          res_q.push_back({raw_l + ofs, raw_r + ofs});
          @(negedge clk);
          adc_done = 1'b0;
          raw_l = ~raw_l;
          raw_r = ~raw_r;
        end
      end
    end
  end
  always @(posedge clk) rd_seen <= rd_req;
  always @(negedge clk) begin
    if (rd_seen === 1'b1) begin
      e8 = rd_q.pop_front();
      `CHK("rd_data", e8, rd_data)
    end
    if (result_valid === 1'b1) begin
      e24 = res_q.pop_front();
      `CHK("result", e24, {loc_t, rem_t})
    end
  end
  initial begin
    {evt_set, therm_lvl, off} = '0;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    for (int p = 0; p < 2; p++) begin
      foreach (ra[i]) rd(ra[i], rv[i]);
      foreach (ro[i]) wr(ro[i], rnd());
    end
    for (int p = 0; p < 2; p++) begin
      d = rnd();
      d[6] = 1'b1;
      d[4] = p[0];
      wr(8'h09, d);
      rd(8'h03, (d & TSC_SETUP_WMASK) | TSC_SETUP_RST);
    end
    d = rnd();
    wr(8'h0A, d);
    rd(8'h04, {4'h0, d[3:0]});
    d = rnd();
    wr(8'h22, d);
    rd(8'h22, d);
    d = rnd();
    @(negedge clk);
    evt_set = d[6:2];
    therm_lvl = d[1:0];
    @(negedge clk);
    evt_set = 5'h00;
    rd(8'h02, {1'b0, d[6:2], d[1:0]});
    rd(8'h02, {6'h00, d[1:0]});
    for (int p = 0; p < 3; p++) begin
      d = rnd();
      e8 = rnd();
      off = d + e8;
      u_host.set_offset(d, e8);
      wr(8'h0F, rnd());
      repeat (20) @(negedge clk);
      rd(8'h11, off);
    end
    wr(8'h0A, 8'hFF);
    wr(8'h09, 8'h00);
    n = 0;
    while (adc_start !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    @(negedge clk);
    while (adc_start !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    `CHK("period", 1'b1, n >= 260 && n <= 285)
    wr(8'h09, 8'h40);
    repeat (20) @(negedge clk);
    `CHK("abort", 1'b1, ab)
    rd(8'h02, {6'h00, therm_lvl});
    repeat (2) @(negedge clk);
    conclude();
  end
  // about twenty-five times the expected run
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
endmodule : testbench
`default_nettype wire
